// [src/bus_bridge_end.sv]
// Processor-side bridge steering the shared buses
`timescale 1ns/10ps
module bus_bridge_end
    import bus_steer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    bus_steer_if.bridge bus,
    input wire logic [ADDR_W-1:0] procAddr,
    input wire logic [DATA_W-1:0] procDataIn,
    input wire logic procWrite,
    input wire logic coprocActive,
    input wire logic [DATA_W-1:0] coprocWrData,
    input wire logic colorSel,
    input wire logic cpuColorBank,
    input wire logic vidColorBank,
    input wire logic [1:0] adapterBits,
    output logic [DATA_W-1:0] procDataOut,
    output logic procDataOe,
    output logic [DATA_W-1:0] coprocRdData,
    output logic romAddr12,
    output logic [ADDR_W-1:0] expAddr,
    output logic [1:0] videoAddrTop,
    output logic colorHalf,
    output logic [ADDR_W-1:0] dmaAddr,
    output logic dmaAddrValid,
    output logic sysTick
);
    typedef struct packed {
        owner_e state;
        logic [HIGH_W-1:0] transOut;
        logic [HIGH_W-1:0] transOe;
        logic [7:0] sharedOut;
        logic sharedOe;
        logic [7:0] dramOut;
        logic dramOe;
        logic [COLOR_W-1:0] colorOut;
        logic colorOe;
        logic [DATA_W-1:0] procDataOut;
        logic procDataOe;
        logic [DATA_W-1:0] coprocRdData;
        logic [7:0] videoRowLatch;
        logic [ADDR_W-1:0] dmaAddr;
        logic dmaAddrValid;
        logic [ADDR_W-1:0] expAddr;
        logic romAddr12;
        logic [1:0] videoTop;
        logic colorHalf;
    } bridge_s;

    localparam bridge_s BRIDGE_RST = '{state: OWN_GAP, default: '0};

    bridge_s s_ff;
    bridge_s nxt_s;
    logic phaseHigh;
    logic [HIGH_W-1:0] highByte;

    // Slow system clock phase
    sys_clock_divider i_sys_clock_divider (
        .clk(clk),
        .rst(rst),
        .phaseHigh(phaseHigh),
        .tick(sysTick)
    );

    // Translated high byte, low coprocessor window moved to boot code
    function automatic logic [HIGH_W-1:0] translateHigh(
        input logic [ADDR_W-1:0] a,
        input logic coproc
    );
        if (coproc && a[15:12] == BIOS_TOP_NIB) begin
            translateHigh = BIOS_HIGH_BASE | {4'h0, a[11:8]};
        end else begin
            translateHigh = a[15:8];
        end
    endfunction

    assign highByte = translateHigh(procAddr, coprocActive);

    // Ownership, next drivers and latches
    always_comb begin
        nxt_s = s_ff;
        nxt_s.dmaAddrValid = 1'b0;
        // Every owner change passes a cycle with nothing driven
        case (s_ff.state)
            OWN_PROC: begin
                if (!bus.cycleOwner) begin
                    nxt_s.state = OWN_GAP;
                end
            end
            OWN_GAP: begin
                if (bus.cycleOwner) begin
                    nxt_s.state = OWN_PROC;
                end else if (bus.dmaActive) begin
                    nxt_s.state = OWN_DMA;
                end else begin
                    nxt_s.state = OWN_VIDEO;
                end
            end
            OWN_VIDEO: begin
                if (bus.cycleOwner || bus.dmaActive) begin
                    nxt_s.state = OWN_GAP;
                end
            end
            OWN_DMA: begin
                if (bus.cycleOwner || !bus.dmaActive) begin
                    nxt_s.state = OWN_GAP;
                end
            end
            default: begin
                nxt_s.state = OWN_GAP;
            end
        endcase

        // All drivers released unless the new state claims them
        nxt_s.transOe = ALL_OFF;
        nxt_s.sharedOe = 1'b0;
        nxt_s.dramOe = 1'b0;
        nxt_s.colorOe = 1'b0;
        nxt_s.procDataOe = 1'b0;
        case (nxt_s.state)
            OWN_PROC: begin
                nxt_s.transOut = highByte;
                nxt_s.transOe = ALL_ON;
                // Row from processor, column from translated
                if (bus.rowColSelect) begin
                    nxt_s.dramOut = highByte;
                end else begin
                    nxt_s.dramOut = procAddr[7:0];
                end
                nxt_s.dramOe = 1'b1;
                nxt_s.sharedOut = procAddr[7:0];
                nxt_s.sharedOe = 1'b1;
                // Color bus joined to data low nibble
                if (colorSel && procWrite) begin
                    nxt_s.colorOut = procDataIn[COLOR_W-1:0];
                    nxt_s.colorOe = 1'b1;
                end
                if (procWrite && coprocActive) begin
                    nxt_s.procDataOut = coprocWrData;
                    nxt_s.procDataOe = 1'b1;
                end else if (!procWrite && colorSel) begin
                    nxt_s.procDataOut = {4'h0, bus.colorLevel};
                    nxt_s.procDataOe = 1'b1;
                end
            end
            OWN_VIDEO: begin
                // Upper four lines high, lower four left to video
                nxt_s.transOut = TRANS_VIDEO_VAL;
                nxt_s.transOe = TRANS_VIDEO_OE;
                // Latch follows in the strobe and column phases, held in the second row phase
                if (bus.rowStrobe || bus.rowColSelect) begin
                    nxt_s.videoRowLatch = bus.dramLevel;
                end
                nxt_s.sharedOut = nxt_s.videoRowLatch;
                nxt_s.sharedOe = 1'b1;
            end
            OWN_DMA: begin
                // Far end drives both buses; reverse them inward
                nxt_s.dmaAddr = {bus.transLevel, bus.sharedLevel};
                nxt_s.dmaAddrValid = 1'b1;
            end
            default: begin
                nxt_s.dmaAddrValid = 1'b0;
            end
        endcase

        // Read data transparent while the slow clock is high
        if (!procWrite && phaseHigh) begin
            nxt_s.coprocRdData = procDataIn;
        end
        nxt_s.expAddr = {bus.transLevel, bus.sharedLevel};
        nxt_s.romAddr12 = bus.transLevel[ROM_A12_BIT];
        nxt_s.videoTop = adapterBits;
        // Only one color half is selected at a time
        if (nxt_s.state == OWN_PROC) begin
            nxt_s.colorHalf = cpuColorBank;
        end else begin
            nxt_s.colorHalf = vidColorBank;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= BRIDGE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Bus side drivers
    assign bus.transDevOut = s_ff.transOut;
    assign bus.transDevOe = s_ff.transOe;
    assign bus.sharedDevOut = s_ff.sharedOut;
    assign bus.sharedDevOe = s_ff.sharedOe;
    assign bus.dramDevOut = s_ff.dramOut;
    assign bus.dramDevOe = s_ff.dramOe;
    assign bus.colorDevOut = s_ff.colorOut;
    assign bus.colorDevOe = s_ff.colorOe;

    // User side outputs
    assign procDataOut = s_ff.procDataOut;
    assign procDataOe = s_ff.procDataOe;
    assign coprocRdData = s_ff.coprocRdData;
    assign romAddr12 = s_ff.romAddr12;
    assign expAddr = s_ff.expAddr;
    assign videoAddrTop = s_ff.videoTop;
    assign colorHalf = s_ff.colorHalf;
    assign dmaAddr = s_ff.dmaAddr;
    assign dmaAddrValid = s_ff.dmaAddrValid;
endmodule // bus_bridge_end

// [src/bus_steer_pkg.sv]
// Constants and types shared by both ends of the bus steering pair
// Behaviour
// - Owner high processor, low video or DMA
// - Eight-bit data, sixteen-bit shared address
// - Owner high write: coprocessor data onto bus
// - Read data latched transparently by system clock
// - Owner high: drive translated high address
// - Coprocessor 0000-0FFF translated to boot code
// - Translated bus drives ROM address 12
// - Expansion port: translated high, shared low
// - Video: lines 12-15 high, 8-11 released
// - External DMA: all translated lines released
// - Owner high: DRAM mux row/column select
// - Owner low: video drives DRAM mux lines
// - Top two video bits from adapter
// - Owner high: shared low from processor
// - Owner low: video row transparent, then latched (code holds only in the second row phase, follows the column)
// - DMA: shared lines reversed, manager unreachable
// - Owner high: color bus joins data low
// - Owner low: color switch open, video drives
// - Only one color RAM half visible
// - DRAM row processor, column translated
package bus_steer_pkg;
    // Widths of the buses
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int HIGH_W = 8;
    localparam int COLOR_W = 4;
    localparam int VID_W = 14;
    // System clock rate as an enable from the core clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUS_PERIOD_NS = 1000;
    localparam int DIV_COUNT = BUS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_COUNT - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(DIV_COUNT / 2);
    // Translation of the low coprocessor window
    localparam logic [3:0] BIOS_TOP_NIB = 4'h0;
    localparam logic [7:0] BIOS_HIGH_BASE = 8'hD0;
    localparam int ROM_A12_BIT = 4;
    // Translated line drive patterns
    localparam logic [7:0] ALL_ON = 8'hFF;
    localparam logic [7:0] ALL_OFF = 8'h00;
    localparam logic [7:0] TRANS_VIDEO_VAL = 8'hF0;
    localparam logic [7:0] TRANS_VIDEO_OE = 8'hF0;
    localparam logic [7:0] TRANS_FAR_OE = 8'h0F;
    // Far end settle count before it drives; the wait lasts one core cycle more
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    localparam logic [1:0] PHASE_ROW = 2'h0;
    // Bridge ownership states
    typedef enum logic [3:0] {
        OWN_PROC = 4'h1,
        OWN_GAP = 4'h2,
        OWN_VIDEO = 4'h4,
        OWN_DMA = 4'h8
    } owner_e;
    // Far end states
    typedef enum logic [4:0] {
        FAR_IDLE = 5'h01,
        FAR_SETTLE = 5'h02,
        FAR_VIDEO = 5'h04,
        FAR_DMA = 5'h08,
        FAR_RELEASE = 5'h10
    } far_e;
endpackage

// [src/bus_steer_if.sv]
// Shared bus wires between the bridge and the video or DMA end
`timescale 1ns/10ps
interface bus_steer_if
    import bus_steer_pkg::*;
(
    input wire logic clk
);
    logic cycleOwner;
    logic dmaActive;
    logic rowStrobe;
    logic rowColSelect;
    logic [HIGH_W-1:0] transDevOut, transDevOe, transFarOut, transFarOe;
    logic [HIGH_W-1:0] transLevel;
    logic [7:0] sharedDevOut, sharedFarOut, sharedLevel;
    logic sharedDevOe, sharedFarOe;
    logic [7:0] dramDevOut, dramFarOut, dramLevel;
    logic dramDevOe, dramFarOe;
    logic [COLOR_W-1:0] colorDevOut, colorFarOut, colorLevel;
    logic colorDevOe, colorFarOe;

    // Wire levels from the enables, undriven lines pull high
    assign transLevel = (transDevOe & transDevOut)
        | (~transDevOe & transFarOe & transFarOut)
        | (~transDevOe & ~transFarOe);
    assign sharedLevel = sharedDevOe ? sharedDevOut
        : (sharedFarOe ? sharedFarOut : 8'hFF);
    assign dramLevel = dramDevOe ? dramDevOut
        : (dramFarOe ? dramFarOut : 8'hFF);
    assign colorLevel = colorDevOe ? colorDevOut
        : (colorFarOe ? colorFarOut : 4'hF);

    modport bridge (
        input cycleOwner, dmaActive, rowStrobe, rowColSelect,
        input transLevel, sharedLevel, dramLevel, colorLevel,
        output transDevOut, transDevOe, sharedDevOut, sharedDevOe,
        output dramDevOut, dramDevOe, colorDevOut, colorDevOe
    );
    modport far (
        output cycleOwner, dmaActive, rowStrobe, rowColSelect,
        input transLevel, sharedLevel, dramLevel, colorLevel,
        output transFarOut, transFarOe, sharedFarOut, sharedFarOe,
        output dramFarOut, dramFarOe, colorFarOut, colorFarOe
    );
endinterface // bus_steer_if

// [src/sys_clock_divider.sv]
// Divider making the slow system clock phase and tick
`timescale 1ns/10ps
module sys_clock_divider
    import bus_steer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output logic phaseHigh,
    output logic tick
);
    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic high;
        logic tick;
    } div_s;

    div_s s_ff;
    div_s nxt_s;

    // Count one slow period, high in its second half
    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (s_ff.count == DIV_LAST) begin
            nxt_s.count = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.count = s_ff.count + 8'h01;
        end
        nxt_s.high = (nxt_s.count >= DIV_HALF);
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign phaseHigh = s_ff.high;
    assign tick = s_ff.tick;
endmodule // sys_clock_divider

// [src/video_dma_end.sv]
// Video chip and external DMA side of the shared buses
`timescale 1ns/10ps
module video_dma_end
    import bus_steer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    bus_steer_if.far bus,
    input wire logic videoReq,
    input wire logic [VID_W-1:0] videoAddr,
    input wire logic [COLOR_W-1:0] videoColor,
    input wire logic dmaReq,
    input wire logic [ADDR_W-1:0] dmaAddr,
    output logic videoGrant,
    output logic dmaGrant
);
    typedef struct packed {
        far_e state;
        logic [1:0] settle;
        logic [1:0] phase;
        logic owner;
        logic dma;
        logic [HIGH_W-1:0] transOut;
        logic [HIGH_W-1:0] transOe;
        logic [7:0] sharedOut;
        logic sharedOe;
        logic [7:0] dramOut;
        logic dramOe;
        logic [COLOR_W-1:0] colorOut;
        logic colorOe;
    } far_s;

    localparam far_s FAR_RST = '{state: FAR_IDLE, owner: 1'b1, default: '0};

    far_s s_ff;
    far_s nxt_s;

    // Ownership requests and bus drive
    always_comb begin
        nxt_s = s_ff;
        nxt_s.phase = s_ff.phase + 2'h1;
        case (s_ff.state)
            FAR_IDLE: begin
                if (videoReq || dmaReq) begin
                    nxt_s.state = FAR_SETTLE;
                    nxt_s.owner = 1'b0;
                    nxt_s.dma = dmaReq;
                    nxt_s.settle = SETTLE_CYCLES;
                end
            end
            FAR_SETTLE: begin
                // Wait for the bridge to let go
                if (s_ff.settle == 2'h0) begin
                    nxt_s.state = s_ff.dma ? FAR_DMA : FAR_VIDEO;
                end else begin
                    nxt_s.settle = s_ff.settle - 2'h1;
                end
            end
            FAR_VIDEO: begin
                if (!videoReq || dmaReq) begin
                    nxt_s.state = FAR_RELEASE;
                end
            end
            FAR_DMA: begin
                if (!dmaReq) begin
                    nxt_s.state = FAR_RELEASE;
                end
            end
            FAR_RELEASE: begin
                nxt_s.state = FAR_IDLE;
                nxt_s.owner = 1'b1;
                nxt_s.dma = 1'b0;
            end
            default: begin
                nxt_s.state = FAR_RELEASE;
            end
        endcase

        nxt_s.transOe = ALL_OFF;
        nxt_s.sharedOe = 1'b0;
        nxt_s.dramOe = 1'b0;
        nxt_s.colorOe = 1'b0;
        case (nxt_s.state)
            FAR_VIDEO: begin
                // Row then column on the DRAM mux lines
                if (nxt_s.phase[1]) begin
                    nxt_s.dramOut = {2'h0, videoAddr[13:8]};
                end else begin
                    nxt_s.dramOut = videoAddr[7:0];
                end
                nxt_s.dramOe = 1'b1;
                nxt_s.transOut = {4'h0, videoAddr[11:8]};
                nxt_s.transOe = TRANS_FAR_OE;
                nxt_s.colorOut = videoColor;
                nxt_s.colorOe = 1'b1;
            end
            FAR_DMA: begin
                nxt_s.transOut = dmaAddr[15:8];
                nxt_s.transOe = ALL_ON;
                nxt_s.sharedOut = dmaAddr[7:0];
                nxt_s.sharedOe = 1'b1;
            end
            default: begin
                nxt_s.transOe = ALL_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= FAR_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Control lines and drivers
    assign bus.cycleOwner = s_ff.owner;
    assign bus.dmaActive = s_ff.dma;
    assign bus.rowStrobe = (s_ff.phase == PHASE_ROW);
    assign bus.rowColSelect = s_ff.phase[1];
    assign bus.transFarOut = s_ff.transOut;
    assign bus.transFarOe = s_ff.transOe;
    assign bus.sharedFarOut = s_ff.sharedOut;
    assign bus.sharedFarOe = s_ff.sharedOe;
    assign bus.dramFarOut = s_ff.dramOut;
    assign bus.dramFarOe = s_ff.dramOe;
    assign bus.colorFarOut = s_ff.colorOut;
    assign bus.colorFarOe = s_ff.colorOe;
    assign videoGrant = (s_ff.state == FAR_VIDEO);
    assign dmaGrant = (s_ff.state == FAR_DMA);
endmodule // video_dma_end

// [testbench/bus_steer_sva.sv]
// Checker watching the shared lines between the two ends
`timescale 1ns/10ps
module bus_steer_sva
    import bus_steer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cycleOwner,
    input wire logic dmaActive,
    input wire logic rowStrobe,
    input wire logic rowColSelect,
    input wire logic [HIGH_W-1:0] transDevOut,
    input wire logic [HIGH_W-1:0] transDevOe,
    input wire logic [HIGH_W-1:0] transFarOe,
    input wire logic [7:0] sharedDevOut,
    input wire logic sharedDevOe,
    input wire logic sharedFarOe,
    input wire logic dramDevOe,
    input wire logic dramFarOe,
    input wire logic colorDevOe,
    input wire logic colorFarOe
);
    logic rstSeen_ff;

    // Reset seen at the last edge, keeps the release edge quiet
    always_ff @(posedge clk) begin
        rstSeen_ff <= rst;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || rstSeen_ff);

    // Never two drivers on one line
    chk_single_driver:
        assert property (!(dramDevOe && dramFarOe)
            && !(colorDevOe && colorFarOe) && !(sharedDevOe && sharedFarOe)
            && (transDevOe & transFarOe) == ALL_OFF)
        else $error("two drivers on a shared line");
    // Processor cycles: bridge drives all address paths
    chk_proc_drive:
        assert property (cycleOwner [*4] |-> sharedDevOe && dramDevOe
            && transDevOe == ALL_ON)
        else $error("bridge idle in processor cycles");
    // Owner low: bridge off DRAM and color lines
    chk_owner_low_off:
        assert property ((!cycleOwner) [*4] |-> !dramDevOe && !colorDevOe)
        else $error("bridge drives while owner low");
    // Video: upper lines pulled high, lower four released
    chk_video_trans:
        assert property ((!cycleOwner && !dmaActive) [*4] |->
            transDevOe == TRANS_VIDEO_OE
            && (transDevOut & TRANS_VIDEO_OE) == TRANS_VIDEO_VAL)
        else $error("wrong translated drive in video cycles");
    // External DMA: translated and shared lines released
    chk_dma_release:
        assert property ((!cycleOwner && dmaActive) [*4] |->
            transDevOe == ALL_OFF && !sharedDevOe)
        else $error("bridge drives during external DMA");
    // Owner change: one cycle with no bridge driver
    chk_owner_turn:
        assert property ($changed(cycleOwner) |=> transDevOe == ALL_OFF
            && !sharedDevOe && !dramDevOe && !colorDevOe)
        else $error("no dead cycle at owner change");
    // Far end off the bus during processor cycles
    chk_far_quiet:
        assert property (cycleOwner |-> transFarOe == ALL_OFF
            && !sharedFarOe && !dramFarOe && !colorFarOe)
        else $error("far end drives in processor cycles");
    // Strobe, row, then two column phases
    chk_phase_order:
        assert property (rowStrobe |-> !rowColSelect
            ##1 (!rowStrobe && !rowColSelect)
            ##1 (!rowStrobe && rowColSelect)
            ##1 (!rowStrobe && rowColSelect) ##1 rowStrobe)
        else $error("row and column phases out of order");
    // Video row address held outside strobe and select
    chk_row_hold:
        assert property ((!cycleOwner && !dmaActive) [*4]
            ##0 (!rowStrobe && !rowColSelect) |=> $stable(sharedDevOut))
        else $error("video row address not held");
endmodule // bus_steer_sva

// [testbench/tb.sv]
// Self-checking bench joining both ends of the bus steering pair
`timescale 1ns/10ps
module tb
    import bus_steer_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] procAddr = 16'h0000;
    logic [DATA_W-1:0] procDataIn = 8'h00;
    logic procWrite = 1'b0;
    logic coprocActive = 1'b0;
    logic [DATA_W-1:0] coprocWrData = 8'h00;
    logic colorSel = 1'b0;
    logic cpuColorBank = 1'b0;
    logic vidColorBank = 1'b0;
    logic [1:0] adapterBits = 2'h0;
    logic videoReq = 1'b0;
    logic [VID_W-1:0] videoAddr = 14'h0000;
    logic [COLOR_W-1:0] videoColor = 4'h0;
    logic dmaReq = 1'b0;
    logic [ADDR_W-1:0] farDmaAddr = 16'h0000;
    logic [DATA_W-1:0] procDataOut, coprocRdData;
    logic procDataOe, romAddr12, colorHalf, dmaAddrValid, sysTick;
    logic [ADDR_W-1:0] expAddr, dmaAddr;
    logic [1:0] videoAddrTop;
    logic videoGrant, dmaGrant;
    int mismatches = 0;
    int check_count = 0;

    // Core clock, 4 ns period
    always #2 clk = ~clk;

    // Both ends joined by the shared bus wires
    bus_steer_if i_bus_steer_if (.clk(clk));
    bus_bridge_end i_bus_bridge_end (.clk(clk), .rst(rst),
        .bus(i_bus_steer_if.bridge), .procAddr(procAddr),
        .procDataIn(procDataIn), .procWrite(procWrite),
        .coprocActive(coprocActive), .coprocWrData(coprocWrData),
        .colorSel(colorSel), .cpuColorBank(cpuColorBank),
        .vidColorBank(vidColorBank), .adapterBits(adapterBits),
        .procDataOut(procDataOut), .procDataOe(procDataOe),
        .coprocRdData(coprocRdData), .romAddr12(romAddr12),
        .expAddr(expAddr), .videoAddrTop(videoAddrTop),
        .colorHalf(colorHalf), .dmaAddr(dmaAddr),
        .dmaAddrValid(dmaAddrValid), .sysTick(sysTick));
    video_dma_end i_video_dma_end (.clk(clk), .rst(rst),
        .bus(i_bus_steer_if.far), .videoReq(videoReq),
        .videoAddr(videoAddr), .videoColor(videoColor), .dmaReq(dmaReq),
        .dmaAddr(farDmaAddr), .videoGrant(videoGrant),
        .dmaGrant(dmaGrant));
    bus_steer_sva i_bus_steer_sva (.clk(clk), .rst(rst),
        .cycleOwner(i_bus_steer_if.cycleOwner),
        .dmaActive(i_bus_steer_if.dmaActive),
        .rowStrobe(i_bus_steer_if.rowStrobe),
        .rowColSelect(i_bus_steer_if.rowColSelect),
        .transDevOut(i_bus_steer_if.transDevOut),
        .transDevOe(i_bus_steer_if.transDevOe),
        .transFarOe(i_bus_steer_if.transFarOe),
        .sharedDevOut(i_bus_steer_if.sharedDevOut),
        .sharedDevOe(i_bus_steer_if.sharedDevOe),
        .sharedFarOe(i_bus_steer_if.sharedFarOe),
        .dramDevOe(i_bus_steer_if.dramDevOe),
        .dramFarOe(i_bus_steer_if.dramFarOe),
        .colorDevOe(i_bus_steer_if.colorDevOe),
        .colorFarOe(i_bus_steer_if.colorFarOe));

    // Compare and count
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Let edges pass, then read settled outputs
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait for a level
    task automatic wait_on(ref logic sig, input logic lvl);
        for (int i = 0; i < 20 && sig !== lvl; i++) cycles(1);
    endtask

    // Bounded wait for the system tick, counting edges
    task automatic tick_wait(output int n);
        n = 0;
        do begin
            cycles(1);
            n++;
        end while (sysTick !== 1'b1 && n < 300);
    endtask

    task automatic complete_run();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Processor addresses onto expansion, ROM line and DRAM mux
    task automatic test_proc_map();
        logic lastSel;
        @(posedge clk);
        procAddr <= 16'h5A3C;
        cycles(3);
        check("expAddr", 16'h5A3C, expAddr);
        check("romAddr12", 1'b1, romAddr12);
        lastSel = i_bus_steer_if.rowColSelect;
        for (int i = 0; i < 8; i++) begin
            cycles(1);
            check("dram", lastSel ? 8'h5A : 8'h3C,
                i_bus_steer_if.dramLevel);
            lastSel = i_bus_steer_if.rowColSelect;
        end
    endtask

    // Low coprocessor window translated, boundary left alone
    task automatic test_translate();
        logic [15:0] exp;
        @(posedge clk);
        coprocActive <= 1'b1;
        procAddr <= 16'h0ABC;
        cycles(3);
        exp = {BIOS_HIGH_BASE | 8'h0A, 8'hBC};
        check("expAddr", exp, expAddr);
        check("romAddr12", exp[12], romAddr12);
        @(posedge clk);
        procAddr <= 16'h1000;
        cycles(3);
        check("expAddr", 16'h1000, expAddr);
    endtask

    // Coprocessor write data, color write and color read
    task automatic test_write_color();
        @(posedge clk);
        procWrite <= 1'b1;
        coprocWrData <= 8'hA5;
        cycles(3);
        check("procDataOut", 8'hA5, procDataOut);
        check("procDataOe", 1'b1, procDataOe);
        @(posedge clk);
        coprocActive <= 1'b0;
        colorSel <= 1'b1;
        procDataIn <= 8'h3C;
        cpuColorBank <= 1'b1;
        cycles(3);
        check("procDataOe", 1'b0, procDataOe);
        check("colorLevel", 4'hC, i_bus_steer_if.colorLevel);
        check("colorHalf", 1'b1, colorHalf);
        @(posedge clk);
        procWrite <= 1'b0;
        cycles(3);
        check("procDataOut", 8'h0F, procDataOut);
        check("procDataOe", 1'b1, procDataOe);
    endtask

    // Read latch follows in the high phase, holds in the low
    task automatic test_read_latch();
        int n;
        @(posedge clk);
        colorSel <= 1'b0;
        procDataIn <= 8'h5A;
        tick_wait(n);
        tick_wait(n);
        check("tick period", 16'(DIV_COUNT), 16'(n));
        check("coprocRdData", 8'h5A, coprocRdData);
        @(posedge clk);
        procDataIn <= 8'hC3;
        cycles(60);
        check("coprocRdData", 8'h5A, coprocRdData);
        tick_wait(n);
        check("coprocRdData", 8'hC3, coprocRdData);
    endtask

    // Video cycle, then return to the processor
    task automatic test_video();
        @(posedge clk);
        cpuColorBank <= 1'b0;
        vidColorBank <= 1'b1;
        adapterBits <= 2'h2;
        videoAddr <= 14'h2A5B;
        videoColor <= 4'h7;
        videoReq <= 1'b1;
        wait_on(videoGrant, 1'b1);
        cycles(2);
        check("videoGrant", 1'b1, videoGrant);
        check("transLevel", 8'hFA, i_bus_steer_if.transLevel);
        check("colorLevel", 4'h7, i_bus_steer_if.colorLevel);
        check("colorHalf", 1'b1, colorHalf);
        check("videoAddrTop", 2'h2, videoAddrTop);
        check("procDataOe", 1'b0, procDataOe);
        @(posedge clk);
        videoReq <= 1'b0;
        wait_on(i_bus_steer_if.cycleOwner, 1'b1);
        cycles(4);
        check("expAddr", 16'h1000, expAddr);
        check("colorHalf", 1'b0, colorHalf);
    endtask

    // External DMA drives the address back to the bridge
    task automatic test_dma();
        @(posedge clk);
        farDmaAddr <= 16'hC123;
        dmaReq <= 1'b1;
        wait_on(dmaGrant, 1'b1);
        cycles(3);
        check("dmaAddr", 16'hC123, dmaAddr);
        check("dmaAddrValid", 1'b1, dmaAddrValid);
        check("cycleOwner", 1'b0, i_bus_steer_if.cycleOwner);
        @(posedge clk);
        dmaReq <= 1'b0;
        wait_on(i_bus_steer_if.cycleOwner, 1'b1);
        cycles(4);
        check("dmaAddrValid", 1'b0, dmaAddrValid);
        check("expAddr", 16'h1000, expAddr);
    endtask

    // Main sequence
    initial begin
        cycles(9);
        @(posedge clk);
        rst <= 1'b0;
        test_proc_map();
        test_translate();
        test_write_color();
        test_read_latch();
        test_video();
        test_dma();
        complete_run();
    end

    // Watchdog, several times the expected run length
    initial begin
        cycles(5000);
        mismatches++;
        complete_run();
    end
endmodule // tb
